// [rtl/gtc_pkg.sv]
package gtc_pkg;
    // Register byte offsets on the bus
    localparam logic [4:0]  REG_CTRL       = 5'h00;
    localparam logic [4:0]  REG_COUNT_LOW  = 5'h04;
    localparam logic [4:0]  REG_COUNT_HIGH = 5'h08;
    localparam logic [4:0]  REG_STATUS     = 5'h0C;
    localparam logic [4:0]  REG_MASK       = 5'h10;

    // Control register field positions
    localparam int CTRL_TIMER_ON_BIT  = 0;
    localparam int CTRL_CLK_SRC_BIT   = 1;
    localparam int CTRL_SYNC_BYP_BIT  = 2;
    localparam int CTRL_OSC_SEL_BIT   = 3;
    localparam int CTRL_PRESCALE_LSB  = 4;
    localparam int CTRL_GATE_EN_BIT   = 6;
    localparam int CTRL_GATE_INV_BIT  = 7;
    localparam int CTRL_GATE_SRC_BIT  = 8;
    localparam int CTRL_W             = 9;

    // Status and mask field positions
    localparam int STAT_OVERFLOW_BIT  = 0;

    // Values after reset, and the top of the count
    localparam logic [8:0]  CTRL_RST      = 9'h000;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [2:0]  PRESCALE_RST  = 3'h0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // Instruction clock is the system clock divided by four
    localparam logic [1:0]  INSTR_DIV_RST  = 2'h0;
    localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
endpackage

// [rtl/gtc_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

module gtc_prescaler #(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // Control
    input  wire logic             tickIn,
    input  wire logic             clear,
    input  wire logic [1:0]       prescaleSelect,
    // Divided tick
    output logic                  tickOut
);
    // Prescale count, hidden from software
    logic [CNT_W-1:0] psCount_ff;
    logic [CNT_W-1:0] nxt_psCount;
    wire  logic [CNT_W-1:0] lastCount = CNT_W'((1 << prescaleSelect) - 1);
    wire  logic             atLast    = (psCount_ff >= lastCount);

    // Divide by 1, 2, 4 or 8; a clear swallows the tick of that cycle
    assign tickOut = tickIn && atLast && !clear;

    // Next prescale count
    always_comb begin
        if (clear) begin
            nxt_psCount = CNT_W'(gtc_pkg::PRESCALE_RST);
        end else if (tickIn) begin
            nxt_psCount = atLast ? CNT_W'(gtc_pkg::PRESCALE_RST) : CNT_W'(psCount_ff + 1'b1);
        end else begin
            nxt_psCount = psCount_ff;
        end
    end

    // Prescale register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            psCount_ff <= CNT_W'(gtc_pkg::PRESCALE_RST);
        end else begin
            psCount_ff <= nxt_psCount;
        end
    end

    property p_ps_clear;
        @(posedge clk_sys) disable iff (!nrst)
        clear |=> (psCount_ff == CNT_W'(gtc_pkg::PRESCALE_RST));
    endproperty
    a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

    property p_ps_div8;
        @(posedge clk_sys) disable iff (!nrst)
        (tickOut && prescaleSelect == 2'h3) |-> (psCount_ff == 3'h7);
    endproperty
    a_ps_div8: assert property (p_ps_div8) else $error("divide by 8 early");
endmodule

`default_nettype wire

// [rtl/gtc_timer.sv]
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - 16-bit up-counter read as two bytes
// - Byte write replaces that byte of count
// - Source bit selects instruction or external clock
// - Internal mode counts prescaled instruction ticks
// - External mode counts rising edges after prescale
// - External edges synchronised or counted directly
// - Falling edge must precede first counted rise
// - Prescale field divides by 1, 2, 4, 8
// - Prescaler hidden, cleared by count writes
// - Crystal oscillator may replace external pin
// - Wrap to zero sets sticky overflow flag
// - Sync bypass counts without instruction alignment
// - Gate enables counting only when enabled
// - Gate invert picks high or low active
module gtc_timer (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic             waitrequest,
    output logic [31:0]      readdata,
    // External sources, asynchronous
    input  wire logic        externalCountClockPin,
    input  wire logic        lowPowerCrystalOsc,
    input  wire logic        gatePin,
    input  wire logic        gateComparator,
    // Results
    output logic             irq,
    output logic [15:0]      countValue
);
    // Word decode shared by every register access
    function automatic logic regHit(input logic [4:0] addr, input logic [4:0] offs);
        regHit = (addr == offs);
    endfunction

    // Bus state
    logic        waitReq_ff;      // High except in the answer cycle
    logic [31:0] rdata_ff;        // Read data, loaded a cycle before the answer
    logic [8:0]  ctrl_ff;         // Control register
    logic [15:0] count_ff;        // The running count
    logic        status_ff;       // Sticky overflow
    logic        mask_ff;         // Overflow interrupt mask
    logic        irq_ff;          // Registered interrupt

    // Synchronisers, first stages read only by second stages
    logic [3:0]  syncA_ff;        // Pin, osc, gate pin, gate comparator
    logic [3:0]  syncB_ff;        // Safe copies
    logic        extPrev_ff;      // Previous external level
    logic        armed_ff;        // Falling edge seen since enable
    logic        pendEdge_ff;     // Edge waiting for instruction tick
    logic [1:0]  instrDiv_ff;     // Instruction clock divider

    // Next values
    logic [31:0] nxt_rdata;
    logic [15:0] nxt_count;
    logic        nxt_status;

    // Bus handshake: accept when waitrequest high, answer next cycle
    wire logic reqNew   = (read || write) && waitReq_ff;
    wire logic doWrite  = write && !waitReq_ff;
    wire logic wrCtrl   = doWrite && regHit(address, gtc_pkg::REG_CTRL);
    wire logic wrLow    = doWrite && regHit(address, gtc_pkg::REG_COUNT_LOW);
    wire logic wrHigh   = doWrite && regHit(address, gtc_pkg::REG_COUNT_HIGH);
    wire logic wrStatus = doWrite && regHit(address, gtc_pkg::REG_STATUS);
    wire logic wrMask   = doWrite && regHit(address, gtc_pkg::REG_MASK);
    wire logic wrCount  = wrLow || wrHigh;

    // Control fields
    wire logic       timerOn     = ctrl_ff[gtc_pkg::CTRL_TIMER_ON_BIT];
    wire logic       clkSrcExt   = ctrl_ff[gtc_pkg::CTRL_CLK_SRC_BIT];
    wire logic       syncBypass  = ctrl_ff[gtc_pkg::CTRL_SYNC_BYP_BIT];
    wire logic       oscSelect   = ctrl_ff[gtc_pkg::CTRL_OSC_SEL_BIT];
    wire logic [1:0] prescaleSel = ctrl_ff[gtc_pkg::CTRL_PRESCALE_LSB +: 2];
    wire logic       gateEnable  = ctrl_ff[gtc_pkg::CTRL_GATE_EN_BIT];
    wire logic       gateInvert  = ctrl_ff[gtc_pkg::CTRL_GATE_INV_BIT];
    wire logic       gateSource  = ctrl_ff[gtc_pkg::CTRL_GATE_SRC_BIT];

    // Instruction tick, one system clock in four
    wire logic instrTick = (instrDiv_ff == gtc_pkg::INSTR_DIV_LAST);

    // External source after synchronisation
    wire logic extLevel  = oscSelect ? syncB_ff[1] : syncB_ff[0];
    wire logic extRise   = extLevel && !extPrev_ff;
    wire logic extFall   = !extLevel && extPrev_ff;
    wire logic extCount  = extRise && armed_ff;

    // Gate: invert 0 counts while low, 1 while high
    wire logic gateLevel = gateSource ? syncB_ff[3] : syncB_ff[2];
    wire logic gateOpen  = !gateEnable || (gateLevel == gateInvert);
    wire logic countEn   = timerOn && gateOpen;

    // Direct edges when bypassing, else aligned to the instruction tick;
    // the bypass path still sees the two pin flops, so it is direct, not clockless
    wire logic extTick   = syncBypass ? extCount : (instrTick && (pendEdge_ff || extCount));
    wire logic srcTick   = clkSrcExt ? extTick : instrTick;
    wire logic psTick;
    wire logic ovfEvent  = psTick && (count_ff == gtc_pkg::COUNT_MAX);

    // Prescaler between source and counter
    gtc_prescaler #(
        .CNT_W          (3)
    ) u_prescaler (
        .clk_sys        (clk_sys),
        .nrst           (nrst),
        .tickIn         (srcTick && countEn),
        .clear          (wrCount),
        .prescaleSelect (prescaleSel),
        .tickOut        (psTick)
    );

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        nxt_rdata = gtc_pkg::RDATA_RST;
        if (regHit(address, gtc_pkg::REG_CTRL)) begin
            nxt_rdata[8:0] = ctrl_ff;
        end else if (regHit(address, gtc_pkg::REG_COUNT_LOW)) begin
            nxt_rdata[7:0] = count_ff[7:0];
        end else if (regHit(address, gtc_pkg::REG_COUNT_HIGH)) begin
            nxt_rdata[7:0] = count_ff[15:8];
        end else if (regHit(address, gtc_pkg::REG_STATUS)) begin
            nxt_rdata[gtc_pkg::STAT_OVERFLOW_BIT] = status_ff;
        end else if (regHit(address, gtc_pkg::REG_MASK)) begin
            nxt_rdata[gtc_pkg::STAT_OVERFLOW_BIT] = mask_ff;
        end
    end

    // Count: a write wins over an increment in the same cycle
    always_comb begin
        nxt_count = count_ff;
        if (wrLow) begin
            nxt_count[7:0] = writedata[7:0];
        end else if (wrHigh) begin
            nxt_count[15:8] = writedata[7:0];
        end else if (psTick) begin
            nxt_count = 16'(count_ff + 16'h0001);
        end
    end

    // Overflow: a new event beats a write-one clear
    always_comb begin
        nxt_status = status_ff;
        if (wrStatus && writedata[gtc_pkg::STAT_OVERFLOW_BIT]) begin
            nxt_status = 1'b0;
        end
        if (ovfEvent) begin
            nxt_status = 1'b1;
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            waitReq_ff <= 1'b1;
            rdata_ff   <= gtc_pkg::RDATA_RST;
        end else begin
            waitReq_ff <= !reqNew;
            rdata_ff   <= reqNew ? nxt_rdata : rdata_ff;
        end
    end

    // Software-visible registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff   <= gtc_pkg::CTRL_RST;
            count_ff  <= gtc_pkg::COUNT_RST;
            status_ff <= 1'b0;
            mask_ff   <= 1'b0;
            irq_ff    <= 1'b0;
        end else begin
            ctrl_ff   <= wrCtrl ? writedata[8:0] : ctrl_ff;
            count_ff  <= nxt_count;
            status_ff <= nxt_status;
            mask_ff   <= wrMask ? writedata[gtc_pkg::STAT_OVERFLOW_BIT] : mask_ff;
            irq_ff    <= nxt_status && (wrMask ? writedata[0] : mask_ff);
        end
    end

    // Two-flop synchronisers for every outside input
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            syncA_ff <= 4'h0;
            syncB_ff <= 4'h0;
        end else begin
            syncA_ff <= {gateComparator, gatePin, lowPowerCrystalOsc, externalCountClockPin};
            syncB_ff <= syncA_ff;
        end
    end

    // Edge tracking; disarmed while off so a stale high level never counts
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            extPrev_ff  <= 1'b0;
            armed_ff    <= 1'b0;
            pendEdge_ff <= 1'b0;
        end else begin
            extPrev_ff  <= extLevel;
            armed_ff    <= timerOn && clkSrcExt && (armed_ff || extFall);
            pendEdge_ff <= !syncBypass && !instrTick && (pendEdge_ff || extCount);
        end
    end

    // Instruction clock divider
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            instrDiv_ff <= gtc_pkg::INSTR_DIV_RST;
        end else begin
            instrDiv_ff <= 2'(instrDiv_ff + 2'h1);
        end
    end

    // Outputs straight from flops
    assign waitrequest = waitReq_ff;
    assign readdata    = rdata_ff;
    assign irq         = irq_ff;
    assign countValue  = count_ff;

    property p_wr_low;
        @(posedge clk_sys) disable iff (!nrst)
        wrLow |=> (count_ff[7:0] == $past(writedata[7:0]) && count_ff[15:8] == $past(count_ff[15:8]));
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low byte write lost");

    property p_wr_high;
        @(posedge clk_sys) disable iff (!nrst)
        wrHigh |=> (count_ff[15:8] == $past(writedata[7:0]) && count_ff[7:0] == $past(count_ff[7:0]));
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("high byte write lost");

    property p_wrap;
        @(posedge clk_sys) disable iff (!nrst)
        (ovfEvent && !wrCount) |=> (count_ff == gtc_pkg::COUNT_RST) && status_ff;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not flag");

    property p_hold_off;
        @(posedge clk_sys) disable iff (!nrst)
        (!timerOn && !wrCount) |=> $stable(count_ff);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved while off");

    property p_gate_shut;
        @(posedge clk_sys) disable iff (!nrst)
        (gateEnable && gateLevel != gateInvert && !wrCount) |=> $stable(count_ff);
    endproperty
    a_gate_shut: assert property (p_gate_shut) else $error("count moved with gate shut");

    property p_int_rate;
        @(posedge clk_sys) disable iff (!nrst)
        (psTick && !clkSrcExt) |-> instrTick;
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("internal tick off instruction clock");

    property p_first_fall;
        @(posedge clk_sys) disable iff (!nrst)
        (clkSrcExt && extRise && !armed_ff) |-> !srcTick;
    endproperty
    a_first_fall: assert property (p_first_fall) else $error("unarmed rise counted");

    property p_sync_align;
        @(posedge clk_sys) disable iff (!nrst)
        (clkSrcExt && !syncBypass && srcTick) |-> instrTick;
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("synced edge off tick");

    property p_bus_answer;
        @(posedge clk_sys) disable iff (!nrst)
        ((read || write) && waitReq_ff) |=> !waitReq_ff ##1 waitReq_ff;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    // Interrupt line mirrors unmasked status, no lag between them
    property p_irq_level;
        @(posedge clk_sys) disable iff (!nrst)
        irq_ff == (status_ff && mask_ff);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");

    property p_sticky;
        @(posedge clk_sys) disable iff (!nrst)
        (status_ff && !(wrStatus && writedata[gtc_pkg::STAT_OVERFLOW_BIT])) |=> status_ff;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flag dropped");

    property p_disarm;
        @(posedge clk_sys) disable iff (!nrst)
        (!timerOn || !clkSrcExt) |=> !armed_ff;
    endproperty
    a_disarm: assert property (p_disarm) else $error("armed while off");

    // Bypassed edge with divide by 1 must land on the very next edge
    property p_bypass_direct;
        @(posedge clk_sys) disable iff (!nrst)
        (clkSrcExt && syncBypass && extCount && countEn && prescaleSel == 2'h0 && !wrCount)
            |=> (count_ff != $past(count_ff));
    endproperty
    a_bypass_direct: assert property (p_bypass_direct) else $error("bypass edge late");
endmodule

`default_nettype wire

// [test/gtc_ext_src.sv]
`timescale 1ns/1ps
`default_nettype none

module gtc_ext_src (
    // Paces every change of level
    input  wire logic clk_sys,
    // Count sources; each stands still between bursts
    output logic      pinLine,
    output logic      oscLine
);
    // Both lines idle low
    initial begin
        pinLine = 1'b0;
        oscLine = 1'b0;
    end

    // One level held 4 cycles: slow enough for the synchroniser
    task automatic set_lvl(input logic lvl, input logic useOsc);
        @(posedge clk_sys);
        if (useOsc) begin
            oscLine <= lvl;
        end else begin
            pinLine <= lvl;
        end
        repeat (3) @(posedge clk_sys);
    endtask

    // Every pulse falls before it rises
    task automatic pulses(input int n, input logic useOsc);
        repeat (n) begin
            set_lvl(1'b0, useOsc);
            set_lvl(1'b1, useOsc);
        end
    endtask
endmodule

`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    // Clock, reset and bus
    logic        clk_sys   = 1'b0;
    logic        nrst      = 1'b0;
    logic [4:0]  address   = 5'h00;
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic        waitrequest;
    logic [31:0] readdata;
    // Sources and results
    logic        pinLine;
    logic        oscLine;
    logic        gatePin   = 1'b0;
    logic        gateCmp   = 1'b0;
    logic        irq;
    logic [15:0] countValue;
    // Tallies and scratch
    int          err_total = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    int          gap;
    // Short register names
    localparam logic [4:0] CT = gtc_pkg::REG_CTRL;
    localparam logic [4:0] LO = gtc_pkg::REG_COUNT_LOW;
    localparam logic [4:0] HI = gtc_pkg::REG_COUNT_HIGH;
    localparam logic [4:0] ST = gtc_pkg::REG_STATUS;
    localparam logic [4:0] MK = gtc_pkg::REG_MASK;

    // 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    gtc_timer u_gtc_timer (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata), .externalCountClockPin(pinLine), .lowPowerCrystalOsc(oscLine),
        .gatePin(gatePin), .gateComparator(gateCmp), .irq(irq), .countValue(countValue));
    gtc_ext_src u_gtc_ext_src (.clk_sys(clk_sys), .pinLine(pinLine), .oscLine(oscLine));

    // Single exit of the run
    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compare with four-state equality
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A wait ran out
    task automatic hang(input string what);
        err_total++;
        $display("[ERR] %s expected done seen timeout", what);
        give_verdict();
    endtask

    // Bus cycle; request held until waitrequest is low at an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        // Sampled at the rising edge, before that edge's updates land
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest && n < 50);
        if (waitrequest) begin
            hang("waitrequest");
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdr(input logic [4:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Control word with timer on; g is {source, invert, enable} of the gate
    function automatic logic [31:0] ctl(input logic ext, input logic byp, input logic osc,
                                        input logic [1:0] ps, input logic [2:0] g);
        ctl = 32'h0000_0000;
        ctl[gtc_pkg::CTRL_TIMER_ON_BIT] = 1'b1;
        ctl[gtc_pkg::CTRL_CLK_SRC_BIT] = ext;
        ctl[gtc_pkg::CTRL_SYNC_BYP_BIT] = byp;
        ctl[gtc_pkg::CTRL_OSC_SEL_BIT] = osc;
        ctl[gtc_pkg::CTRL_PRESCALE_LSB +: 2] = ps;
        ctl[gtc_pkg::CTRL_GATE_EN_BIT] = g[0];
        ctl[gtc_pkg::CTRL_GATE_INV_BIT] = g[1];
        ctl[gtc_pkg::CTRL_GATE_SRC_BIT] = g[2];
    endfunction

    // Cycles until the count moves, into gap
    task automatic wait_change();
        logic [15:0] v;
        v = countValue;
        gap = 0;
        do begin
            @(negedge clk_sys);
            gap++;
        end while (countValue === v && gap < 200);
        if (countValue === v) begin
            hang("count change");
        end
    endtask

    // Values out of reset, unmapped place
    task automatic t_reset();
        chk("irq", 32'h0000_0000, 32'(irq));
        rdr(CT);
        chk("ctrl", 32'h0000_0000, rd);
        rdr(HI);
        chk("count high", 32'h0000_0000, rd);
        wr(5'h14, 32'hFFFF_FFFF);
        rdr(5'h14);
        chk("unmapped", 32'h0000_0000, rd);
    endtask

    // Byte halves written and read back
    task automatic t_bytes();
        wr(LO, 32'h0000_005A);
        wr(HI, 32'h0000_00C3);
        rdr(LO);
        chk("low byte", 32'h0000_005A, rd);
        rdr(HI);
        chk("high byte", 32'h0000_00C3, rd);
        wr(LO, 32'h0000_0011);
        @(negedge clk_sys);
        chk("count", 32'h0000_C311, 32'(countValue));
    endtask

    // Interval per prescale code, then hold while off
    task automatic t_prescale();
        logic [15:0] v;
        for (int ps = 0; ps < 4; ps++) begin
            wr(CT, 32'h0000_0000);
            wr(CT, ctl(1'b0, 1'b0, 1'b0, 2'(ps), 3'h0));
            wait_change();
            wait_change();
            chk("interval", 32'(4 << ps), 32'(gap));
        end
        // External, bypassed, but timer off: edges must be ignored
        wr(CT, ctl(1'b1, 1'b1, 1'b0, 2'h0, 3'h0) ^ 32'h0000_0001);
        repeat (4) @(negedge clk_sys);
        v = countValue;
        u_gtc_ext_src.pulses(3, 1'b0);
        chk("held", 32'(v), 32'(countValue));
    endtask

    // Wrap, sticky flag, mask and clear
    task automatic t_ovf();
        wr(MK, 32'h0000_0001);
        wr(LO, 32'h0000_00FF);
        wr(HI, 32'h0000_00FF);
        wr(CT, ctl(1'b0, 1'b0, 1'b0, 2'h0, 3'h0));
        wait_change();
        chk("wrap", 32'h0000_0000, 32'(countValue));
        wr(CT, 32'h0000_0000);
        chk("irq set", 32'h0000_0001, 32'(irq));
        wr(MK, 32'h0000_0000);
        @(negedge clk_sys);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(MK, 32'h0000_0001);
        rdr(ST);
        chk("flag sticky", 32'h0000_0001, rd);
        wr(ST, 32'h0000_0001);
        rdr(ST);
        chk("flag cleared", 32'h0000_0000, rd);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
    endtask

    // Pin and crystal, synchronised and bypassed; a first unarmed rise
    task automatic t_ext();
        logic byp;
        logic osc;
        for (int k = 0; k < 4; k++) begin
            byp = k[0];
            osc = k[1];
            wr(CT, 32'h0000_0000);
            wr(LO, 32'h0000_0000);
            wr(HI, 32'h0000_0000);
            // Both lines low, so switching source makes no false fall
            u_gtc_ext_src.set_lvl(1'b0, !osc);
            u_gtc_ext_src.set_lvl(1'b0, osc);
            wr(CT, ctl(1'b1, byp, osc, 2'h0, 3'h0));
            u_gtc_ext_src.set_lvl(1'b1, osc);
            u_gtc_ext_src.pulses(5, osc);
            repeat (16) @(negedge clk_sys);
            chk("edges", 32'h0000_0005, 32'(countValue));
        end
    endtask

    // Count write clears a half-full divide-by-8
    task automatic t_clear();
        wr(CT, 32'h0000_0000);
        wr(LO, 32'h0000_0000);
        wr(CT, ctl(1'b1, 1'b0, 1'b0, 2'h3, 3'h0));
        u_gtc_ext_src.pulses(5, 1'b0);
        wr(LO, 32'h0000_0000);
        u_gtc_ext_src.pulses(7, 1'b0);
        repeat (16) @(negedge clk_sys);
        chk("after clear", 32'h0000_0000, 32'(countValue));
        u_gtc_ext_src.pulses(1, 1'b0);
        repeat (16) @(negedge clk_sys);
        chk("eighth edge", 32'h0000_0001, 32'(countValue));
    endtask

    // Gate closed then open, for each polarity and source
    task automatic t_gate(input logic [2:0] g, input logic shut);
        wr(CT, 32'h0000_0000);
        wr(LO, 32'h0000_0000);
        @(posedge clk_sys);
        gatePin <= shut ^ g[2];
        gateCmp <= shut;
        wr(CT, ctl(1'b0, 1'b0, 1'b0, 2'h0, g));
        repeat (40) @(negedge clk_sys);
        chk("gate shut", 32'h0000_0000, 32'(countValue));
        @(posedge clk_sys);
        gatePin <= !shut ^ g[2];
        gateCmp <= !shut;
        repeat (40) @(negedge clk_sys);
        chk("gate open", 32'h0000_0001, 32'(countValue != 16'h0000));
        // Gate shut again but disabled: it must not hold the count
        @(posedge clk_sys);
        gatePin <= shut ^ g[2];
        gateCmp <= shut;
        wr(CT, ctl(1'b0, 1'b0, 1'b0, 2'h0, g & 3'b110));
        wait_change();
        chk("gate ignored", 32'h0000_0001, 32'(gap <= 8));
    endtask

    // Reset, then every scenario
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_bytes();
        t_prescale();
        t_ovf();
        t_ext();
        t_clear();
        t_gate(3'b001, 1'b1);
        t_gate(3'b111, 1'b0);
        give_verdict();
    end
endmodule

`default_nettype wire
